// File: rtl/uart_rx_status_defines.svh
// Register map, field positions, reset values and timing counts of the receive status block.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef UART_RX_STATUS_DEFINES_SVH
`define UART_RX_STATUS_DEFINES_SVH

// Byte offsets
`define OFS_STATUS      8'h00
`define OFS_DATA        8'h04
`define OFS_CTRL        8'h08
`define OFS_BAUD        8'h0c

// Status bit positions
`define ST_PARITY       7
`define ST_NOISE        6
`define ST_FRAMING      5
`define ST_OVERRUN      4
`define ST_RX_IDLE      3
`define ST_RX_AVAIL     2
`define ST_TX_IDLE      1
`define ST_TX_EMPTY     0

// Control bit positions
`define CT_RX_EN        0
`define CT_PAR_EN       1
`define CT_PAR_ODD      2
`define CT_RX_IE        3

// Reset values
`define CTRL_RESET      4'h1
`define BAUD_RESET      16'h0035
`define TX_FLAGS_RESET  2'h3

// Oversampling: sixteen ticks a bit, three votes around the middle
`define OS_LAST         4'hf
`define OS_VOTE0        4'h7
`define OS_VOTE2        4'h9
`define DATA_BITS       4'h8

`endif

// File: rtl/uart_rx_status_pkg.sv
// Types for the receive status block: receiver states and the block's whole state.
// Needs uart_rx_status_defines.svh on the include path.
`include "uart_rx_status_defines.svh"

package uart_rx_status_pkg;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'h01,
    RX_START  = 5'h02,
    RX_DATA   = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP   = 5'h10
  } rx_state_t;

  // Buffer entry: parity, framing, noise error then the data byte
  typedef logic [10:0] rx_entry_t;

  typedef struct packed {
    logic             rx_meta;
    logic             rx_sync;
    logic [15:0]      baud_cnt;
    rx_state_t        state;
    logic [3:0]       os_cnt;
    logic [3:0]       bit_cnt;
    logic [2:0]       votes;
    logic [7:0]       shift;
    logic             par_acc;
    logic             perr;
    logic             noise;
    logic [1:0][10:0] fifo;
    logic [1:0]       fifo_cnt;
    logic [7:0]       data;
    logic             avail;
    logic             err_parity;
    logic             err_noise;
    logic             err_framing;
    logic             err_overrun;
    logic             armed;
    logic             armed_avail;
    logic [3:0]       ctrl;
    logic [15:0]      baud_div;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic             irq;
  } state_t;

endpackage

// File: rtl/uart_rx_status.sv
// Serial receiver with its status flags, two-entry receive buffer and AHB-Lite registers.
// Assumes one 100 MHz clock, a zero-wait AHB-Lite master and an asynchronous rx pin.
//
// Functional notes
// R1: Status register is read only; writes change no flag.
// R2: Parity error flag bit 7 set on wrong parity, only when parity enabled.
// R3: Status read then data register access clears parity, noise, framing, overrun.
// R4: Noise flag bit 6 set on noisy input, never for an overrun character.
// R5: Framing error flag bit 5 set when a character's stop bit is low.
// R6: Overrun flag bit 4 set on buffer overflow; blocks further received characters.
// R7: Receiver idle bit 3 low from start detection until stop completion.
// R8: Remote transmitter holds the line high between stop and next start.
// R9: Data-available bit 2 set on transfer to data register; interrupt if enabled.
// R10: Error flags set in same cycle as data-available flag for that word.
// R11: Data-available clears after status read then data read, once buffer empty.
// R12: Received characters pass a two-deep buffer before the data register.
// R13: Characters arrive least significant bit first, shifted at the baud rate.
// R14: Character completing with full buffer is an overrun and is discarded.
// R15: Noise detected by disagreement among three samples within each bit.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps

module uart_rx_status (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic [31:0]      hrdata_o,
  output logic             hresp_o,
  // Serial line and receive interrupt
  input  wire logic        rx_i,
  output logic             rx_irq_o
);

  uart_rx_status_pkg::state_t    s_reg;
  uart_rx_status_pkg::state_t    s_next;

  // Combinational helpers
  logic                          tick;
  logic                          vote;
  logic                          disagree;
  logic                          done;
  uart_rx_status_pkg::rx_entry_t done_entry;
  logic                          buf_in_valid;
  logic                          buf_in_ready;
  logic                          buf_out_valid;
  logic                          buf_out_ready;
  logic                          addr_ok;
  logic [7:0]                    addr;
  logic                          rd_status;
  logic                          rd_data;
  logic                          wr_data;
  logic                          data_access;
  logic                          consume;
  logic [7:0]                    status;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = s_reg.rdata;
  assign rx_irq_o    = s_reg.irq;

  assign addr    = haddr_i[7:0];
  assign addr_ok = hsel_i && hready_i && htrans_i[1] && (haddr_i[31:8] == 24'h000000);

  assign rd_status   = addr_ok && !hwrite_i && (addr == `OFS_STATUS);
  assign rd_data     = addr_ok && !hwrite_i && (addr == `OFS_DATA);
  assign wr_data     = s_reg.wr_pend && (s_reg.wr_addr == `OFS_DATA);
  assign data_access = rd_data || wr_data;
  // Only a read after the status read hands the word over
  assign consume     = rd_data && s_reg.armed_avail; // R11

  assign status = {s_reg.err_parity, s_reg.err_noise, s_reg.err_framing, s_reg.err_overrun,
                   (s_reg.state == uart_rx_status_pkg::RX_IDLE), s_reg.avail,
                   `TX_FLAGS_RESET};

  assign vote     = (s_reg.votes[0] & s_reg.votes[1]) | (s_reg.votes[0] & s_reg.votes[2])
                  | (s_reg.votes[1] & s_reg.votes[2]);
  assign disagree = !(&s_reg.votes) && (|s_reg.votes); // R15

  assign tick = (s_reg.baud_cnt >= s_reg.baud_div);

  assign buf_in_ready  = (s_reg.fifo_cnt != 2'h2);
  assign buf_out_valid = (s_reg.fifo_cnt != 2'h0);
  assign buf_out_ready = !(s_reg.avail && !consume);

  always_comb begin
    s_next = s_reg;
    done = 1'b0;
    done_entry = {s_reg.perr, 1'b0, s_reg.noise, s_reg.shift};

    // Two-flop synchroniser on the serial input
    s_next.rx_meta = rx_i;
    s_next.rx_sync = s_reg.rx_meta;

    // Oversampling divider
    if (tick) begin
      s_next.baud_cnt = 16'h0000;
    end else begin
      s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;
    end

    // Receiver
    if (!s_reg.ctrl[`CT_RX_EN]) begin
      s_next.state = uart_rx_status_pkg::RX_IDLE;
    end else if (tick) begin
      if (s_reg.state != uart_rx_status_pkg::RX_IDLE) begin
        s_next.os_cnt = s_reg.os_cnt + 4'h1;
        if (s_reg.os_cnt >= `OS_VOTE0 && s_reg.os_cnt <= `OS_VOTE2) begin
          s_next.votes = {s_reg.rx_sync, s_reg.votes[2:1]};
        end
      end
      case (s_reg.state)
        uart_rx_status_pkg::RX_IDLE: begin
          if (!s_reg.rx_sync) begin
            s_next.state   = uart_rx_status_pkg::RX_START; // R7
            s_next.os_cnt  = 4'h0;
            s_next.bit_cnt = 4'h0;
            s_next.par_acc = 1'b0;
            s_next.perr    = 1'b0;
            s_next.noise   = 1'b0;
          end
        end
        uart_rx_status_pkg::RX_START: begin
          if (s_reg.os_cnt == `OS_LAST) begin
            s_next.noise = disagree; // R15
            if (vote) begin
              s_next.state = uart_rx_status_pkg::RX_IDLE;
            end else begin
              s_next.state = uart_rx_status_pkg::RX_DATA;
            end
          end
        end
        uart_rx_status_pkg::RX_DATA: begin
          if (s_reg.os_cnt == `OS_LAST) begin
            s_next.noise   = s_reg.noise | disagree; // R15
            s_next.shift   = {vote, s_reg.shift[7:1]}; // R13
            s_next.par_acc = s_reg.par_acc ^ vote;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            if (s_reg.bit_cnt == `DATA_BITS - 4'h1) begin
              if (s_reg.ctrl[`CT_PAR_EN]) begin
                s_next.state = uart_rx_status_pkg::RX_PARITY;
              end else begin
                s_next.state = uart_rx_status_pkg::RX_STOP;
              end
            end
          end
        end
        uart_rx_status_pkg::RX_PARITY: begin
          if (s_reg.os_cnt == `OS_LAST) begin
            s_next.noise = s_reg.noise | disagree;
            s_next.perr  = s_reg.par_acc ^ vote ^ s_reg.ctrl[`CT_PAR_ODD]; // R2
            s_next.state = uart_rx_status_pkg::RX_STOP;
          end
        end
        uart_rx_status_pkg::RX_STOP: begin
          if (s_reg.os_cnt == `OS_LAST) begin
            // Idle again once the stop bit completes
            s_next.state = uart_rx_status_pkg::RX_IDLE; // R7
            done = 1'b1;
            done_entry = {s_reg.perr && s_reg.ctrl[`CT_PAR_EN], !vote,
                          s_reg.noise | disagree, s_reg.shift}; // R5
          end
        end
        default: begin
          s_next.state = uart_rx_status_pkg::RX_IDLE;
        end
      endcase
    end

    // Two-entry buffer; while overrun stands nothing more enters
    // A discarded word never reaches the flags, so its noise is not reported
    buf_in_valid = done && !s_reg.err_overrun; // R6 R4
    if (done && (!buf_in_ready || s_reg.err_overrun)) begin
      s_next.err_overrun = 1'b1; // R14
    end

    // Software clears pending errors by status read then data access
    if (data_access && s_reg.armed) begin
      s_next.err_parity  = 1'b0; // R3
      s_next.err_noise   = 1'b0;
      s_next.err_framing = 1'b0;
      if (!(done && (!buf_in_ready || s_reg.err_overrun))) begin
        s_next.err_overrun = 1'b0;
      end
      s_next.armed       = 1'b0;
      s_next.armed_avail = 1'b0;
    end

    if (consume) begin
      s_next.avail = 1'b0; // R11
    end

    // Buffer head moves into the data register with its flags in one cycle
    if (buf_out_valid && buf_out_ready) begin
      s_next.data        = s_reg.fifo[0][7:0];
      s_next.avail       = 1'b1; // R9
      s_next.err_noise   = s_next.err_noise | s_reg.fifo[0][8]; // R10
      s_next.err_framing = s_next.err_framing | s_reg.fifo[0][9];
      s_next.err_parity  = s_next.err_parity | s_reg.fifo[0][10];
      s_next.fifo[0]     = s_reg.fifo[1];
      if (buf_in_valid && buf_in_ready) begin
        s_next.fifo[s_reg.fifo_cnt - 2'h1] = done_entry; // R12
      end else begin
        s_next.fifo_cnt = s_reg.fifo_cnt - 2'h1;
      end
    end else if (buf_in_valid && buf_in_ready) begin
      s_next.fifo[s_reg.fifo_cnt[0]] = done_entry; // R12
      s_next.fifo_cnt = s_reg.fifo_cnt + 2'h1;
    end
    s_next.irq = buf_out_valid && buf_out_ready && s_reg.ctrl[`CT_RX_IE]; // R9

    // Status read arms the clearing sequence
    if (rd_status) begin
      s_next.armed       = 1'b1;
      s_next.armed_avail = s_reg.avail;
    end

    // Read data captured in the address phase
    if (addr_ok && !hwrite_i) begin
      case (addr)
        `OFS_STATUS: s_next.rdata = {24'h000000, status};
        `OFS_DATA:   s_next.rdata = {24'h000000, s_reg.data};
        `OFS_CTRL:   s_next.rdata = {28'h0000000, s_reg.ctrl};
        `OFS_BAUD:   s_next.rdata = {16'h0000, s_reg.baud_div};
        default:     s_next.rdata = 32'h00000000;
      endcase
    end

    // Writes land in the data phase; the status word has no write path
    s_next.wr_pend = addr_ok && hwrite_i;
    s_next.wr_addr = addr;
    if (s_reg.wr_pend) begin
      case (s_reg.wr_addr)
        `OFS_CTRL: s_next.ctrl     = hwdata_i[3:0];
        `OFS_BAUD: s_next.baud_div = hwdata_i[15:0];
        default:   s_next.wr_pend  = addr_ok && hwrite_i; // R1
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg          <= '0;
      s_reg.rx_meta  <= 1'b1;
      s_reg.rx_sync  <= 1'b1;
      s_reg.state    <= uart_rx_status_pkg::RX_IDLE;
      s_reg.ctrl     <= `CTRL_RESET;
      s_reg.baud_div <= `BAUD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// File: tb/uart_line_model.sv
// Model of the remote serial transmitter that drives the receive pin.
// Assumes a divider of 0 in the block, so that one bit lasts BIT system clocks.
`timescale 1ns/100ps
module uart_line_model #(parameter int BIT = 16) (
  // System clock
  input  wire logic clock_i,
  // Serial line
  output logic      rx_o
);
  initial rx_o = 1'b1;
  // Parity mode pm: 0 none, 1 even, 2 odd; bp bad parity, fs low stop, gl one-clock glitch
  task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bp, fs, gl);
    logic [10:0] f;
    int          n;
    f = {~fs, (^d) ^ pm[1] ^ bp, d, 1'b0};
    n = (pm != 2'h0) ? 11 : 10;
    if (pm == 2'h0) f[9] = ~fs;
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < BIT; c++) begin
        rx_o <= (gl && i == 1 && c == 10) ? ~f[i] : f[i];
        @(posedge clock_i);
      end
    end
    rx_o <= 1'b1;
  endtask
endmodule

// File: tb/uart_rx_status_sva.sv
// Checker of the receive status block, watching its top-level ports only.
// Assumes the bus hready is tied to the block's hreadyout.
`timescale 1ns/100ps
module uart_rx_status_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  // AHB-Lite slave
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic [31:0] hrdata_o,
  input wire logic        hresp_o,
  // Serial line and interrupt
  input wire logic        rx_i,
  input wire logic        rx_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic rd_t;
  assign rd_t = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  property p_okay; hreadyout_o && !hresp_o; endproperty
  property p_hold; !rd_t |=> $stable(hrdata_o); endproperty
  property p_status; rd_t && haddr_i == 32'h0 |=> hrdata_o[31:8] == 24'h0 && hrdata_o[1:0] == 2'h3;
  endproperty
  property p_data; rd_t && haddr_i == 32'h4 |=> hrdata_o[31:8] == 24'h0; endproperty
  property p_unmapped; rd_t && haddr_i == 32'h10 |=> hrdata_o == 32'h0; endproperty
  property p_irq; rx_irq_o |=> !rx_irq_o; endproperty
  property p_ctrl; rd_t && haddr_i == 32'h8 |=> hrdata_o[31:4] == 28'h0; endproperty
  property p_baud; rd_t && haddr_i == 32'hc |=> hrdata_o[31:16] == 16'h0; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  a_hold: assert property (p_hold) else $error("read data changed without a read");
  a_status: assert property (p_status) else $error("status fixed bits wrong");
  a_data: assert property (p_data) else $error("data read upper bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_irq: assert property (p_irq) else $error("receive interrupt longer than a cycle");
  a_ctrl: assert property (p_ctrl) else $error("control read upper bits set");
  a_baud: assert property (p_baud) else $error("divider read upper bits set");
  c_irq: cover property (rx_irq_o);
  c_status: cover property (rd_t && haddr_i == 32'h0);
  c_data: cover property (rd_t && haddr_i == 32'h4);
endmodule
bind uart_rx_status uart_rx_status_sva u_sva (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
  .rx_i(rx_i), .rx_irq_o(rx_irq_o));

// File: tb/uart_rx_status_tb.sv
// Testbench of the receive status block: AHB-Lite master tasks and a serial line model.
// Assumes zero-wait AHB-Lite answers and the divider written to 0 before traffic.
`timescale 1ns/100ps
module uart_rx_status_tb;
  logic        clock_i, arst_n_i, hsel, hwrite, rx, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  int          num_errors, n_compared;
  uart_rx_status u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .rx_i(rx), .rx_irq_o(irq));
  uart_line_model u_line (.clock_i(clock_i), .rx_o(rx));
  always #5 clock_i = ~clock_i;
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    @(posedge clock_i); while (hready !== 1'b1) @(posedge clock_i);
    htrans <= 2'h0; hwdata <= wd;
    @(posedge clock_i); while (hready !== 1'b1) @(posedge clock_i);
    d = hrdata;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(n, e, d);
  endtask
  task automatic frame(input logic [7:0] v, input logic [1:0] pm, input logic bp, fs, gl);
    u_line.send(v, pm, bp, fs, gl);
    repeat (10) @(posedge clock_i);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    report_and_stop;
  end
  initial begin
    clock_i = 1'b0; arst_n_i = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0; num_errors = 0; n_compared = 0;
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    rchk("status", 8'h00, 32'h0b);
    rchk("ctrl", 8'h08, 32'h1);
    rchk("baud", 8'h0c, 32'h35);
    rchk("unmapped", 8'h10, 32'h0);
    ahb(1'b1, 8'h00, 32'hff);
    rchk("status", 8'h00, 32'h0b);
    ahb(1'b1, 8'h0c, 32'h0);
    ahb(1'b1, 8'h08, 32'h9);
    $display("test registers done");
    fork
      u_line.send(8'ha5, 2'h0, 1'b0, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge clock_i);
        ahb(1'b0, 8'h00, 32'h0);
        chk("idle", 32'h0, {31'h0, d[3]});
      end
    join
    for (int k = 0; k < 100 && irq !== 1'b1; k++) @(negedge clock_i);
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clock_i);
    rchk("status", 8'h00, 32'h0f);
    rchk("data", 8'h04, 32'ha5);
    rchk("status", 8'h00, 32'h0b);
    $display("test receive done");
    for (int m = 1; m < 3; m++) begin
      ahb(1'b1, 8'h08, (m == 1) ? 32'h3 : 32'h7);
      frame(8'h3c, m[1:0], 1'b1, 1'b0, 1'b0);
      rchk("parity", 8'h00, 32'h8f);
      rchk("data", 8'h04, 32'h3c);
      rchk("status", 8'h00, 32'h0b);
    end
    $display("test parity done");
    ahb(1'b1, 8'h08, 32'h1);
    frame(8'h5a, 2'h0, 1'b0, 1'b1, 1'b0);
    rchk("framing", 8'h00, 32'h2f);
    ahb(1'b1, 8'h04, 32'h0);
    rchk("status", 8'h00, 32'h0f);
    rchk("data", 8'h04, 32'h5a);
    frame(8'h69, 2'h0, 1'b0, 1'b0, 1'b1);
    rchk("noise", 8'h00, 32'h4f);
    rchk("data", 8'h04, 32'h69);
    rchk("status", 8'h00, 32'h0b);
    $display("test errors done");
    for (int i = 0; i < 4; i++) frame(8'h10 + i[7:0], 2'h0, 1'b0, 1'b0, 1'b0);
    rchk("overrun", 8'h00, 32'h1f);
    rchk("data", 8'h04, 32'h10);
    for (int i = 1; i < 3; i++) begin
      rchk("status", 8'h00, 32'h0f);
      rchk("data", 8'h04, 32'h10 + i);
    end
    rchk("status", 8'h00, 32'h0b);
    $display("test overrun done");
    report_and_stop;
  end
endmodule
